// ### rtl/fbso_defines.svh
// Constants shared by both ends of the fieldbus station link.
`ifndef FBSO_DEFINES_SVH
`define FBSO_DEFINES_SVH
// Clock period in nanoseconds.
`define FBSO_CLK_NS 4
// Least and longest refresh interval per station, in nanoseconds.
`define FBSO_REFRESH_MIN_NS 1100000
`define FBSO_REFRESH_MAX_NS 141000000
// Interval counts in cycles; the least rounds up, the longest down.
`define FBSO_REFRESH_MIN_CYC \
  ((`FBSO_REFRESH_MIN_NS + `FBSO_CLK_NS - 1) / `FBSO_CLK_NS)
`define FBSO_REFRESH_MAX_CYC (`FBSO_REFRESH_MAX_NS / `FBSO_CLK_NS)
// Stored occupancy setting codes.
`define FBSO_OCC_V1_LEGACY 8'h00
`define FBSO_OCC_V1_SINGLE 8'h01
`define FBSO_OCC_V2_DOUBLE 8'h0c
`define FBSO_OCC_V2_QUAD 8'h0e
`define FBSO_OCC_V2_OCT 8'h12
`define FBSO_OCC_PLC_SINGLE 8'h64
`define FBSO_OCC_PLC_DOUBLE 8'h70
`define FBSO_OCC_PLC_QUAD 8'h72
`define FBSO_OCC_PLC_OCT 8'h76
// Station number range, lowest and highest.
`define FBSO_STN_MIN 7'h01
`define FBSO_STN_MAX 7'h40
// Instruction code that clears the alarm history (arbitrary choice).
`define FBSO_INSTR_ALARM_CLEAR 8'hf4
// Master register byte offsets.
`define FBSO_REG_CTRL 8'h00
`define FBSO_REG_CMD 8'h04
`define FBSO_REG_INSTR 8'h08
`define FBSO_REG_DATA 8'h0c
`define FBSO_REG_STATUS 8'h10
`define FBSO_REG_REPLY 8'h14
`define FBSO_REG_ALLOC 8'h18
`define FBSO_REG_IRQ_STAT 8'h1c
`define FBSO_REG_IRQ_MASK 8'h20
// Command register bit positions.
`define FBSO_CMD_RAM 0
`define FBSO_CMD_NV 1
`define FBSO_CMD_INSTR 2
`define FBSO_CMD_ERR_RESET 3
// Interrupt status bit positions.
`define FBSO_IRQ_REPLY 0
`define FBSO_IRQ_ERROR 1
`define FBSO_IRQ_MISMATCH 2
// Reset value of the master allocation multiple.
`define FBSO_ALLOC_RESET 4'h1
`endif

// ### rtl/fbso_pkg.sv
// Types used by the station end of the fieldbus station link.
package fbso_pkg;
  // Active occupancy layouts of the station.
  typedef enum logic [3:0] {
    occ_v1_legacy,
    occ_v1_single,
    occ_v2_double,
    occ_v2_quad,
    occ_v2_oct,
    occ_plc_single,
    occ_plc_double,
    occ_plc_quad,
    occ_plc_oct
  } fbso_occ_t;
endpackage

// ### rtl/fbso_link_if.sv
// Link between the master station and the remote device station.
`timescale 1ns/1ps
interface fbso_link_if;
  logic        comm_start;   // Master has started communication.
  logic        refresh;      // One-cycle pulse: a refresh frame.
  logic        ry_ram;       // Frequency write to RAM request.
  logic        ry_nv;        // Frequency write to RAM and NV request.
  logic        ry_instr;     // Instruction execution request.
  logic        ry_err_reset; // Error reset request.
  logic [15:0] rww_instr;    // Instruction code word.
  logic [15:0] rww_data;     // Write data word.
  logic        reply_valid;  // One-cycle pulse: station answer.
  logic        rx_ram_done;  // RAM write executed in this refresh.
  logic        rx_nv_done;   // NV write executed in this refresh.
  logic        rx_instr_done;// Instruction executed in this refresh.
  logic        rx_error;     // Drive alarm active.
  logic        rx_ready;     // Station ready.
  logic [15:0] rwr_reply;    // Reply word.
  logic [3:0]  occ_mult;     // Active occupancy multiple.

  // The master drives the frame, the station the answer.
  modport master (
    output comm_start, refresh, ry_ram, ry_nv, ry_instr, ry_err_reset,
    output rww_instr, rww_data,
    input  reply_valid, rx_ram_done, rx_nv_done, rx_instr_done,
    input  rx_error, rx_ready, rwr_reply, occ_mult
  );
  modport station (
    input  comm_start, refresh, ry_ram, ry_nv, ry_instr, ry_err_reset,
    input  rww_instr, rww_data,
    output reply_valid, rx_ram_done, rx_nv_done, rx_instr_done,
    output rx_error, rx_ready, rwr_reply, occ_mult
  );
endinterface

// ### rtl/fbso_station.sv
// Remote device station end: occupancy, command arbitration, resets.
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
`include "fbso_defines.svh"

// What this block does
// R1 - Answer every refresh frame, repeated continuously.
// R2 - Master starts communication before refresh runs.
// R3 - Setting 0 legacy; 1,12,14,18 select occupancy.
// R4 - Settings 100,112,114,118 select PLC variants.
// R5 - Legacy mode executes one of three requests.
// R6 - Legacy mode: instruction upper byte is expansion.
// R7 - Master allocates the same multiple as station.
// R8 - Version 1 master cannot serve multiple occupancy.
// R9 - Occupancy change applies only after drive reset.
// R10 - Error reset resets drive only during alarm.
// R11 - Alarm clear erases past eight alarm records.
// R12 - Station number 1 to 64 sets base index.
// R13 - Mode loaded at reset; unsupported keeps previous.
module fbso_station (
  input  wire logic            clk,
  input  wire logic            rst_n,
  fbso_link_if.station         link,
  input  wire logic [7:0]      occupancy_setting,
  input  wire logic [6:0]      station_number_setting,
  input  wire logic            alarm_active,
  output fbso_pkg::fbso_occ_t  occupancy_mode,
  output logic [5:0]           station_base,
  output logic                 freq_ram_write,
  output logic                 freq_nv_write,
  output logic                 instr_exec,
  output logic [7:0]           instr_code,
  output logic [15:0]          write_data,
  output logic [7:0]           link_param_exp,
  output logic                 drive_reset,
  output logic                 alarm_history_clear
);

  // Set at reset and by every drive reset; the next cycle loads settings.
  logic                load_pending;
  // Communication has been started by the master.
  logic                started;
  // Decoded setting and its validity.
  fbso_pkg::fbso_occ_t dec_mode;
  logic                dec_valid;
  // Station number check.
  logic                stn_valid;
  // Legacy layout is active.
  wire logic           legacy;
  // Frame is accepted for execution.
  wire logic           take;
  // Requests granted in this frame.
  wire logic           grant_ram;
  wire logic           grant_nv;
  wire logic           grant_instr;
  // Error reset request that really resets the drive.
  wire logic           do_reset;
  // Multiple of the active occupancy.
  logic [3:0]          mult;

  // Decode the stored setting; anything unlisted is unsupported.
  always_comb begin
    dec_valid = 1'b1;
    case (occupancy_setting)
      `FBSO_OCC_V1_LEGACY:  dec_mode = fbso_pkg::occ_v1_legacy; // R3
      `FBSO_OCC_V1_SINGLE:  dec_mode = fbso_pkg::occ_v1_single; // R3
      `FBSO_OCC_V2_DOUBLE:  dec_mode = fbso_pkg::occ_v2_double; // R3
      `FBSO_OCC_V2_QUAD:    dec_mode = fbso_pkg::occ_v2_quad; // R3
      `FBSO_OCC_V2_OCT:     dec_mode = fbso_pkg::occ_v2_oct; // R3
      `FBSO_OCC_PLC_SINGLE: dec_mode = fbso_pkg::occ_plc_single; // R4
      `FBSO_OCC_PLC_DOUBLE: dec_mode = fbso_pkg::occ_plc_double; // R4
      `FBSO_OCC_PLC_QUAD:   dec_mode = fbso_pkg::occ_plc_quad; // R4
      `FBSO_OCC_PLC_OCT:    dec_mode = fbso_pkg::occ_plc_oct; // R4
      default: begin
        dec_mode  = occupancy_mode;
        dec_valid = 1'b0;
      end
    endcase
  end

  // Multiple reported to the master so it can check its allocation.
  always_comb begin
    case (occupancy_mode)
      fbso_pkg::occ_v2_double,
      fbso_pkg::occ_plc_double: mult = 4'h2;
      fbso_pkg::occ_v2_quad,
      fbso_pkg::occ_plc_quad:   mult = 4'h4;
      fbso_pkg::occ_v2_oct,
      fbso_pkg::occ_plc_oct:    mult = 4'h8;
      default:                  mult = 4'h1;
    endcase
  end

  // Station numbers outside 1 to 64 are not taken.
  assign stn_valid = (station_number_setting >= `FBSO_STN_MIN) &&
                     (station_number_setting <= `FBSO_STN_MAX); // R12

  assign legacy = (occupancy_mode == fbso_pkg::occ_v1_legacy);

  // Frames before the start command are ignored.
  assign take = link.refresh && (started || link.comm_start); // R2

  // Legacy layout: a fixed priority leaves only one request standing.
  assign grant_ram   = take && link.ry_ram; // R5
  assign grant_nv    = take && link.ry_nv &&
                       !(legacy && link.ry_ram); // R5
  assign grant_instr = take && link.ry_instr &&
                       !(legacy && (link.ry_ram || link.ry_nv)); // R5

  // Error reset only counts while the drive is in alarm.
  assign do_reset = take && link.ry_err_reset && alarm_active; // R10

  // Load the settings one cycle after each reset, never under it.
  // Catching the straps by a clocked process keeps the asynchronous
  // reset constant-only.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      load_pending <= 1'b1;
    end else begin
      load_pending <= do_reset; // R9
    end
  end

  // Active occupancy changes only on a load; later edits wait.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      occupancy_mode <= fbso_pkg::occ_v1_legacy; // R3
    end else if (load_pending && dec_valid) begin
      occupancy_mode <= dec_mode; // R9 R13
    end
  end

  // Base index follows the station number; a bad number keeps the old.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      station_base <= 6'h00;
    end else if (load_pending && stn_valid) begin
      station_base <= 6'(station_number_setting - `FBSO_STN_MIN); // R12
    end
  end

  // Remember the start command; a drive reset keeps communication up.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      started <= 1'b0;
    end else if (link.comm_start) begin
      started <= 1'b1; // R2
    end
  end

  // Drive-side command pulses, one cycle each per granted request.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      freq_ram_write <= 1'b0;
      freq_nv_write  <= 1'b0;
      instr_exec     <= 1'b0;
    end else begin
      freq_ram_write <= grant_ram; // R5
      freq_nv_write  <= grant_nv; // R5
      instr_exec     <= grant_instr; // R5
    end
  end

  // Instruction and data words are latched only for executed commands.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_code <= 8'h00;
      write_data <= 16'h0000;
    end else if (grant_instr || grant_ram || grant_nv) begin
      instr_code <= link.rww_instr[7:0];
      write_data <= link.rww_data;
    end
  end

  // In the legacy layout the upper byte carries the expansion setting;
  // other layouts leave it untouched.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link_param_exp <= 8'h00;
    end else if (take && legacy) begin
      link_param_exp <= link.rww_instr[15:8]; // R6
    end
  end

  // Reset and history clear pulses toward the drive.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_reset         <= 1'b0;
      alarm_history_clear <= 1'b0;
    end else begin
      drive_reset         <= do_reset; // R10
      alarm_history_clear <= grant_instr &&
        (link.rww_instr[7:0] == `FBSO_INSTR_ALARM_CLEAR); // R11
    end
  end

  // Answer each accepted frame in the next cycle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link.reply_valid   <= 1'b0;
      link.rx_ram_done   <= 1'b0;
      link.rx_nv_done    <= 1'b0;
      link.rx_instr_done <= 1'b0;
    end else begin
      link.reply_valid   <= take; // R1
      link.rx_ram_done   <= grant_ram;
      link.rx_nv_done    <= grant_nv;
      link.rx_instr_done <= grant_instr;
    end
  end

  // Status words: the reply echoes the executed instruction code.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link.rx_error  <= 1'b0;
      link.rx_ready  <= 1'b0;
      link.rwr_reply <= 16'h0000;
      link.occ_mult  <= 4'h1;
    end else begin
      link.rx_error <= alarm_active;
      link.rx_ready <= (started || link.comm_start) && !alarm_active;
      link.occ_mult <= mult; // R7
      if (grant_instr) begin
        link.rwr_reply <= {8'h00, link.rww_instr[7:0]};
      end
    end
  end

endmodule

// ### rtl/fbso_master.sv
// Master station end: refresh timer, command registers, interrupts.
`timescale 1ns/1ps
`include "fbso_defines.svh"
module fbso_master #(
  parameter int unsigned REFRESH_CYCLES = `FBSO_REFRESH_MIN_CYC,
  parameter bit          VER2_CAPABLE   = 1'b1
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  fbso_link_if.master      link,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata,
  output logic             irq
);

  logic        start;     // Communication start, software controlled.
  logic [3:0]  cmd;       // Requests waiting for the next refresh.
  logic [15:0] instr;     // Instruction code word to send.
  logic [15:0] data;      // Write data word to send.
  logic [4:0]  status;    // Last answer flags.
  logic [15:0] reply;     // Last reply word.
  logic [3:0]  alloc;     // Data allocation multiple for the station.
  logic [2:0]  irq_stat;  // Sticky events.
  logic [2:0]  irq_mask;  // Event enables.
  logic [31:0] tmr;       // Refresh interval counter.
  wire logic   fire;      // Refresh frame this cycle.
  wire logic   mismatch;  // Allocation does not fit the station.
  wire logic [2:0] events;
  wire logic [3:0] next_cmd;
  logic [31:0] next_rdata;

  // Decoded writes.
  wire logic wr_ctrl  = wr && (addr == `FBSO_REG_CTRL);
  wire logic wr_cmd   = wr && (addr == `FBSO_REG_CMD);
  wire logic wr_instr = wr && (addr == `FBSO_REG_INSTR);
  wire logic wr_data  = wr && (addr == `FBSO_REG_DATA);
  wire logic wr_alloc = wr && (addr == `FBSO_REG_ALLOC);
  wire logic wr_istat = wr && (addr == `FBSO_REG_IRQ_STAT);
  wire logic wr_imask = wr && (addr == `FBSO_REG_IRQ_MASK);

  // Refresh repeats as long as communication is started.
  assign fire = start && (tmr == REFRESH_CYCLES - 1); // R1 R2

  // A version 1 master cannot serve a multiple, and the allocation
  // must equal the station's multiple.
  assign mismatch = (link.occ_mult != alloc) ||
                    (!VER2_CAPABLE && link.occ_mult != 4'h1); // R7 R8

  assign events = {link.reply_valid && mismatch,
                   link.reply_valid && link.rx_error,
                   link.reply_valid};

  // Requests clear as they are sent; a same-cycle write sets them again.
  assign next_cmd = (fire ? 4'h0 : cmd) | (wr_cmd ? wdata[3:0] : 4'h0);

  // Read mux; unmapped addresses read zero.
  always_comb begin
    case (addr)
      `FBSO_REG_CTRL:     next_rdata = {31'h0, start};
      `FBSO_REG_CMD:      next_rdata = {28'h0, cmd};
      `FBSO_REG_INSTR:    next_rdata = {16'h0, instr};
      `FBSO_REG_DATA:     next_rdata = {16'h0, data};
      `FBSO_REG_STATUS:   next_rdata = {27'h0, status};
      `FBSO_REG_REPLY:    next_rdata = {16'h0, reply};
      `FBSO_REG_ALLOC:    next_rdata = {28'h0, alloc};
      `FBSO_REG_IRQ_STAT: next_rdata = {29'h0, irq_stat};
      `FBSO_REG_IRQ_MASK: next_rdata = {29'h0, irq_mask};
      default:            next_rdata = 32'h0;
    endcase
  end

  // Software registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start    <= 1'b0;
      instr    <= 16'h0000;
      data     <= 16'h0000;
      alloc    <= `FBSO_ALLOC_RESET;
      irq_mask <= 3'h0;
    end else begin
      if (wr_ctrl)  start    <= wdata[0];
      if (wr_instr) instr    <= wdata[15:0];
      if (wr_data)  data     <= wdata[15:0];
      if (wr_alloc) alloc    <= wdata[3:0];
      if (wr_imask) irq_mask <= wdata[2:0];
    end
  end

  // Pending requests, read data and timer.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd   <= 4'h0;
      rdata <= 32'h0;
      tmr   <= 32'h0;
    end else begin
      cmd   <= next_cmd;
      rdata <= rd ? next_rdata : 32'h0;
      tmr   <= (!start || fire) ? 32'h0 : tmr + 32'h1;
    end
  end

  // Frame outputs; requests pulse for one cycle with the refresh, start and words follow their registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link.comm_start   <= 1'b0;
      link.refresh      <= 1'b0;
      link.ry_ram       <= 1'b0;
      link.ry_nv        <= 1'b0;
      link.ry_instr     <= 1'b0;
      link.ry_err_reset <= 1'b0;
      link.rww_instr    <= 16'h0000;
      link.rww_data     <= 16'h0000;
    end else begin
      link.comm_start   <= start; // R2
      link.refresh      <= fire; // R1
      link.ry_ram       <= fire && cmd[`FBSO_CMD_RAM];
      link.ry_nv        <= fire && cmd[`FBSO_CMD_NV];
      link.ry_instr     <= fire && cmd[`FBSO_CMD_INSTR];
      link.ry_err_reset <= fire && cmd[`FBSO_CMD_ERR_RESET];
      link.rww_instr    <= instr;
      link.rww_data     <= data;
    end
  end

  // Answer capture and sticky interrupts; a new event beats a clear.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status   <= 5'h00;
      reply    <= 16'h0000;
      irq_stat <= 3'h0;
      irq      <= 1'b0;
    end else begin
      if (link.reply_valid) begin
        status <= {link.rx_ready, link.rx_error, link.rx_instr_done,
                   link.rx_nv_done, link.rx_ram_done};
        reply  <= link.rwr_reply;
      end
      irq_stat <= (irq_stat & ~(wr_istat ? wdata[2:0] : 3'h0)) | events;
      irq      <= |(((irq_stat & ~(wr_istat ? wdata[2:0] : 3'h0))
                     | events) & irq_mask);
    end
  end

endmodule

// ### bench/fbso_link_sva.sv
// Concurrent checks on the link that joins the master and station ends.
`timescale 1ns/1ps
module fbso_link_sva #(
  parameter int unsigned REFRESH_CYCLES = 20
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        comm_start,
  input wire logic        refresh,
  input wire logic        ry_ram,
  input wire logic        ry_nv,
  input wire logic        ry_instr,
  input wire logic        ry_err_reset,
  input wire logic [15:0] rww_instr,
  input wire logic        reply_valid,
  input wire logic        rx_ram_done,
  input wire logic        rx_nv_done,
  input wire logic        rx_instr_done,
  input wire logic [15:0] rwr_reply,
  input wire logic [3:0]  occ_mult
);
  int unsigned gap;   // Cycles since the last frame while started.
  logic        had;   // A frame has been seen since the start bit rose.
  logic [3:0]  since; // Cycles since an error reset frame, saturating.

  // Track frame spacing; a dropped start bit restarts the count.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap <= 0;
      had <= 1'b0;
    end else if (!comm_start || refresh) begin
      gap <= 0;
      had <= comm_start;
    end else begin
      gap <= gap + 1;
    end
  end

  // The layout may only move shortly after reset or an error reset frame.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      since <= 4'h0;
    end else if (refresh && ry_err_reset) begin
      since <= 4'h0;
    end else if (since != 4'hf) begin
      since <= since + 4'h1;
    end
  end

  // Every check samples on the rising edge and rests in reset.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_reply_after_frame: assert property (
    refresh && comm_start |=> reply_valid)
    else $error("frame left unanswered");
  a_reply_needs_frame: assert property (
    reply_valid |-> $past(refresh))
    else $error("answer without a frame");
  a_frame_gap: assert property (
    refresh |=> !refresh [*8])
    else $error("frames too close");
  a_frame_period: assert property (
    (refresh && had |-> gap >= REFRESH_CYCLES - 2 && gap <= REFRESH_CYCLES)
    and (gap <= REFRESH_CYCLES + 2))
    else $error("refresh interval off");
  a_done_needs_req: assert property (
    reply_valid |-> (rx_ram_done <= $past(ry_ram)) &&
    (rx_nv_done <= $past(ry_nv)) && (rx_instr_done <= $past(ry_instr)))
    else $error("done flag without request");
  a_ram_first: assert property (
    reply_valid && $past(ry_ram) |-> rx_ram_done)
    else $error("ram write not executed");
  a_reply_code: assert property (
    reply_valid && rx_instr_done |->
    rwr_reply == ($past(rww_instr) & 16'h00ff))
    else $error("reply code wrong");
  a_mult_legal: assert property (
    occ_mult inside {4'h1, 4'h2, 4'h4, 4'h8})
    else $error("illegal multiple");
  a_mult_steady: assert property (
    $changed(occ_mult) |-> since < 4'h8)
    else $error("layout moved without reset");
endmodule

// ### bench/tb.sv
// Self-checking bench: master and station ends joined over the link.
`timescale 1ns/1ps
`include "fbso_defines.svh"
module tb;
  localparam int unsigned REF = 20; // Shortened refresh interval.
  logic        clk;
  logic        rst_n;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        irq;
  logic [7:0]  occupancy_setting;
  logic [6:0]  station_number_setting;
  logic        alarm_active;
  fbso_pkg::fbso_occ_t occupancy_mode;
  logic [5:0]  station_base;
  logic        freq_ram_write;
  logic        freq_nv_write;
  logic        instr_exec;
  logic [7:0]  instr_code;
  logic [15:0] write_data;
  logic [7:0]  link_param_exp;
  logic        drive_reset;
  logic        alarm_history_clear;
  int          n_errors;
  int          tests_run;
  fbso_pkg::fbso_occ_t prev;
  // All station pulses side by side, counted per command window.
  wire logic [4:0] pulses = {alarm_history_clear, drive_reset, instr_exec,
                             freq_nv_write, freq_ram_write};
  // Strap table: setting, station number, expected mode, multiple, base.
  logic [7:0] t_set [10] = '{8'h0c, 8'h0e, 8'h12, 8'h64, 8'h70, 8'h72,
                             8'h01, 8'h00, 8'h76, 8'h05};
  logic [6:0] t_stn [10] = '{7'h40, 7'h00, 7'h01, 7'h10, 7'h20, 7'h3f,
                             7'h02, 7'h05, 7'h41, 7'h00};
  fbso_pkg::fbso_occ_t t_mode [10] = '{fbso_pkg::occ_v2_double,
    fbso_pkg::occ_v2_quad, fbso_pkg::occ_v2_oct, fbso_pkg::occ_plc_single,
    fbso_pkg::occ_plc_double, fbso_pkg::occ_plc_quad,
    fbso_pkg::occ_v1_single, fbso_pkg::occ_v1_legacy,
    fbso_pkg::occ_plc_oct, fbso_pkg::occ_plc_oct};
  logic [3:0] t_mult [10] = '{4'h2, 4'h4, 4'h8, 4'h1, 4'h2, 4'h4,
                              4'h1, 4'h1, 4'h8, 4'h8};
  logic [5:0] t_base [10] = '{6'h3f, 6'h3f, 6'h00, 6'h0f, 6'h1f, 6'h3e,
                              6'h01, 6'h04, 6'h04, 6'h04};

  fbso_link_if fbso_link_if_inst ();
  fbso_master #(.REFRESH_CYCLES(REF)) fbso_master_inst (.clk(clk),
    .rst_n(rst_n), .link(fbso_link_if_inst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
  fbso_station fbso_station_inst (.clk(clk), .rst_n(rst_n),
    .link(fbso_link_if_inst), .occupancy_setting(occupancy_setting),
    .station_number_setting(station_number_setting),
    .alarm_active(alarm_active), .occupancy_mode(occupancy_mode),
    .station_base(station_base), .freq_ram_write(freq_ram_write),
    .freq_nv_write(freq_nv_write), .instr_exec(instr_exec),
    .instr_code(instr_code), .write_data(write_data),
    .link_param_exp(link_param_exp), .drive_reset(drive_reset),
    .alarm_history_clear(alarm_history_clear));
  fbso_link_sva #(.REFRESH_CYCLES(REF)) fbso_link_sva_inst (.clk(clk),
    .rst_n(rst_n), .comm_start(fbso_link_if_inst.comm_start),
    .refresh(fbso_link_if_inst.refresh), .ry_ram(fbso_link_if_inst.ry_ram),
    .ry_nv(fbso_link_if_inst.ry_nv), .ry_instr(fbso_link_if_inst.ry_instr),
    .ry_err_reset(fbso_link_if_inst.ry_err_reset),
    .rww_instr(fbso_link_if_inst.rww_instr),
    .reply_valid(fbso_link_if_inst.reply_valid),
    .rx_ram_done(fbso_link_if_inst.rx_ram_done),
    .rx_nv_done(fbso_link_if_inst.rx_nv_done),
    .rx_instr_done(fbso_link_if_inst.rx_instr_done),
    .rwr_reply(fbso_link_if_inst.rwr_reply),
    .occ_mult(fbso_link_if_inst.occ_mult));

  // Free-running 250 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Compare one value; case inequality lets no unknown slip through.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe.
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // One-cycle read strobe; the data stand only in the following cycle.
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Issue a command and note which pulses came, and whether any twice.
  task automatic run_cmd(input logic [3:0] cmd, input logic [4:0] exp);
    logic [4:0] seen;
    logic [4:0] twice;
    seen = 5'h00;
    twice = 5'h00;
    wr_reg(`FBSO_REG_CMD, {28'h0000000, cmd});
    repeat (2 * REF + 6) begin
      @(posedge clk);
      #1;
      twice = twice | (seen & pulses);
      seen = seen | pulses;
    end
    check({22'h0, twice, seen}, {27'h0, exp});
  endtask

  // Print the counts and the verdict, then stop.
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // A hang is cut short and counted as a mismatch.
  initial begin
    #100000;
    n_errors++;
    wrap_up();
  end

  initial begin
    rst_n = 1'b0;
    addr = 8'h00;
    wdata = 32'h00000000;
    wr = 1'b0;
    rd = 1'b0;
    occupancy_setting = 8'h00;
    station_number_setting = 7'h05;
    alarm_active = 1'b0;
    n_errors = 0;
    tests_run = 0;
    prev = fbso_pkg::occ_v1_legacy;
    wait_cyc(2);
    rst_n <= 1'b1;
    rd_chk(`FBSO_REG_ALLOC, 32'h00000001);
    rd_chk(`FBSO_REG_IRQ_MASK, 32'h00000000);
    wr_reg(8'h3c, 32'hffffffff);
    rd_chk(8'h3c, 32'h00000000);
    check(32'(occupancy_mode), 32'(fbso_pkg::occ_v1_legacy));
    check({26'h0000000, station_base}, 32'h00000004);
    wait_cyc(2 * REF);
    rd_chk(`FBSO_REG_IRQ_STAT, 32'h00000000);
    $display("test reset done");
    // Legacy layout: one of three requests, upper byte as expansion.
    wr_reg(`FBSO_REG_CTRL, 32'h00000001);
    wr_reg(`FBSO_REG_IRQ_MASK, 32'h00000001);
    wr_reg(`FBSO_REG_DATA, 32'h00001234);
    run_cmd(4'h1, 5'h01);
    check({16'h0000, write_data}, 32'h00001234);
    check({31'h00000000, irq}, 32'h00000001);
    wr_reg(`FBSO_REG_IRQ_MASK, 32'h00000000);
    wait_cyc(2);
    check({31'h00000000, irq}, 32'h00000000);
    wr_reg(`FBSO_REG_INSTR, 32'h0000a53c);
    run_cmd(4'h7, 5'h01);
    run_cmd(4'h4, 5'h04);
    check({24'h000000, instr_code}, 32'h0000003c);
    check({24'h000000, link_param_exp}, 32'h000000a5);
    rd_chk(`FBSO_REG_REPLY, 32'h0000003c);
    run_cmd(4'h8, 5'h00);
    wr_reg(`FBSO_REG_INSTR, 32'h000000f4);
    run_cmd(4'h4, 5'h14);
    $display("test legacy done");
    // Every setting code, then an unsupported one, through drive resets.
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      occupancy_setting <= t_set[i];
      station_number_setting <= t_stn[i];
      wait_cyc(2 * REF);
      check(32'(occupancy_mode), 32'(prev));
      @(posedge clk);
      alarm_active <= 1'b1;
      run_cmd(4'h8, 5'h08);
      rd_chk(`FBSO_REG_STATUS, 32'h00000008);
      @(posedge clk);
      alarm_active <= 1'b0;
      check(32'(occupancy_mode), 32'(t_mode[i]));
      check(32'(fbso_link_if_inst.occ_mult), 32'(t_mult[i]));
      check(32'(station_base), 32'(t_base[i]));
      prev = t_mode[i];
    end
    run_cmd(4'h7, 5'h17);
    rd_chk(`FBSO_REG_STATUS, 32'h00000010);
    wr_reg(`FBSO_REG_ALLOC, 32'h00000008);
    rd_chk(`FBSO_REG_ALLOC, 32'h00000008);
    rd_chk(`FBSO_REG_IRQ_STAT, 32'h00000007);
    wr_reg(`FBSO_REG_IRQ_STAT, 32'h00000007);
    wait_cyc(2 * REF);
    rd_chk(`FBSO_REG_IRQ_STAT, 32'h00000001);
    $display("test occupancy done");
    // Stop the link, clear the sticky bits, then reset in mid-run.
    wr_reg(`FBSO_REG_CTRL, 32'h00000000);
    wait_cyc(2 * REF);
    wr_reg(`FBSO_REG_IRQ_STAT, 32'h00000007);
    rd_chk(`FBSO_REG_IRQ_STAT, 32'h00000000);
    @(posedge clk);
    rst_n <= 1'b0;
    wait_cyc(2);
    rst_n <= 1'b1;
    wait_cyc(3);
    check(32'(occupancy_mode), 32'(fbso_pkg::occ_v1_legacy));
    check({26'h0000000, station_base}, 32'h00000000);
    $display("test second reset done");
    wrap_up();
  end
endmodule
